//--- bench/dual_port_block_ram_bench.sv
// self-checking bench: 32-bit write-new port a, 8-bit read-old port b
module dual_port_block_ram_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic en_a, we_a, en_b, we_b;
    logic [8:0] addr_a;
    logic [31:0] wd_a, rd_a;
    logic [3:0] wp_a, rp_a;
    logic [10:0] addr_b;
    logic [7:0] wd_b, rd_b;
    logic [0:0] wp_b, rp_b;
    logic [35:0] ra;
    logic [8:0] rb;
    int fails = 0;
    int checks_done = 0;

    always #4 clk = ~clk;

    dual_port_block_ram #(.DW_B(8), .MODE_B(bram_pkg::READ_OLD)) i_dual_port_block_ram (
        .clk(clk), .rst_n(rst_n),
        .port_en_a(en_a), .port_we_a(we_a), .port_addr_a(addr_a), .port_wdata_a(wd_a),
        .port_wparity_a(wp_a), .port_rdata_a(rd_a), .port_rparity_a(rp_a),
        .port_en_b(en_b), .port_we_b(we_b), .port_addr_b(addr_b), .port_wdata_b(wd_b),
        .port_wparity_b(wp_b), .port_rdata_b(rd_b), .port_rparity_b(rp_b)
    );

    fabric_user i_fabric_user (
        .clk(clk),
        .en_a(en_a), .we_a(we_a), .addr_a(addr_a), .wd_a(wd_a), .wp_a(wp_a),
        .rd_a(rd_a), .rp_a(rp_a),
        .en_b(en_b), .we_b(we_b), .addr_b(addr_b), .wd_b(wd_b), .wp_b(wp_b),
        .rd_b(rd_b), .rp_b(rp_b)
    );

    task automatic chk_a(input string what, input logic [35:0] exp, input logic [35:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_b(input string what, input logic [8:0] exp, input logic [8:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_reset();
        repeat (4) @(posedge clk);
        #1;
        chk_a("a out in reset", 36'h0, {rd_a, rp_a});
        chk_b("b out in reset", 9'h0, {rd_b, rp_b});
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        $display("reset done");
    endtask

    task automatic test_write_new();
        i_fabric_user.cyc(1, 1, 9'h003, 32'hA1B2C3D4, 4'hA, 0, 0, 11'h0, 8'h0, 0, ra, rb);
        chk_a("a write echo", {32'hA1B2C3D4, 4'hA}, ra);
        i_fabric_user.cyc(1, 0, 9'h003, 32'h0, 4'h0, 0, 0, 11'h0, 8'h0, 0, ra, rb);
        chk_a("a read back", {32'hA1B2C3D4, 4'hA}, ra);
        $display("write new done");
    endtask

    task automatic test_read_old();
        i_fabric_user.cyc(0, 0, 9'h0, 32'h0, 4'h0, 1, 1, 11'h00D, 8'h5C, 0, ra, rb);
        chk_b("b old byte", {8'hC3, 1'h1}, rb);
        i_fabric_user.cyc(0, 0, 9'h0, 32'h0, 4'h0, 1, 0, 11'h00D, 8'h0, 0, ra, rb);
        chk_b("b read back", {8'h5C, 1'h0}, rb);
        i_fabric_user.cyc(1, 0, 9'h003, 32'h0, 4'h0, 0, 0, 11'h0, 8'h0, 0, ra, rb);
        chk_a("a sees b lane", {32'hA1B25CD4, 4'h8}, ra);
        $display("read old done");
    endtask

    task automatic test_hold();
        i_fabric_user.cyc(0, 1, 9'h003, 32'hFFFF0000, 4'hF, 0, 1, 11'h00D, 8'h00, 1, ra, rb);
        chk_a("a held", {32'hA1B25CD4, 4'h8}, ra);
        chk_b("b held", {8'h5C, 1'h0}, rb);
        i_fabric_user.cyc(1, 0, 9'h003, 32'h0, 4'h0, 1, 0, 11'h00D, 8'h0, 0, ra, rb);
        chk_a("a not written", {32'hA1B25CD4, 4'h8}, ra);
        chk_b("b not written", {8'h5C, 1'h0}, rb);
        $display("hold done");
    endtask

    task automatic test_both();
        i_fabric_user.cyc(1, 1, 9'h1FF, 32'hDEADBEEF, 4'h6, 0, 0, 11'h0, 8'h0, 0, ra, rb);
        i_fabric_user.cyc(1, 1, 9'h1FF, 32'h11223344, 4'h5, 1, 0, 11'h7FF, 8'h0, 0, ra, rb);
        chk_a("a write top", {32'h11223344, 4'h5}, ra);
        chk_b("b read same edge", {8'hDE, 1'h0}, rb);
        i_fabric_user.cyc(1, 0, 9'h1FF, 32'h0, 4'h0, 1, 1, 11'h7FF, 8'h77, 1, ra, rb);
        chk_a("a read same edge", {32'h11223344, 4'h5}, ra);
        chk_b("b old top byte", {8'h11, 1'h0}, rb);
        i_fabric_user.cyc(1, 0, 9'h1FF, 32'h0, 4'h0, 0, 0, 11'h0, 8'h0, 0, ra, rb);
        chk_a("a sees top lane", {32'h77223344, 4'hD}, ra);
        $display("both ports done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // tests need under 100 cycles
    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        conclude();
    end

    initial begin
        test_reset();
        test_write_new();
        test_read_old();
        test_hold();
        test_both();
        conclude();
    end
endmodule

//--- bench/fabric_user.sv
// fabric-side user logic model driving both ports of the block ram
module fabric_user (
    // clock
    input wire logic clk,
    // port a
    output logic en_a,
    output logic we_a,
    output logic [8:0] addr_a,
    output logic [31:0] wd_a,
    output logic [3:0] wp_a,
    input wire logic [31:0] rd_a,
    input wire logic [3:0] rp_a,
    // port b
    output logic en_b,
    output logic we_b,
    output logic [10:0] addr_b,
    output logic [7:0] wd_b,
    output logic [0:0] wp_b,
    input wire logic [7:0] rd_b,
    input wire logic [0:0] rp_b
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {en_a, we_a, addr_a, wd_a, wp_a} = '0;
        {en_b, we_b, addr_b, wd_b, wp_b} = '0;
    end

    // one request per port held over one edge, then released
    task automatic cyc(input logic ea, wa, input logic [8:0] aa, input logic [31:0] da,
                       input logic [3:0] pa, input logic eb, wb, input logic [10:0] ab,
                       input logic [7:0] db, input logic pb,
                       output logic [35:0] ra, output logic [8:0] rb);
        @(posedge clk);
        {en_a, we_a, addr_a, wd_a, wp_a} <= {ea, wa, aa, da, pa};
        {en_b, we_b, addr_b, wd_b, wp_b} <= {eb, wb, ab, db, pb};
        @(posedge clk);
        // released lines carry the inverse of the last value, with enable driven low
        {en_a, we_a, addr_a, wd_a, wp_a} <= {1'h0, ~wa, ~aa, ~da, ~pa};
        {en_b, we_b, addr_b, wd_b, wp_b} <= {1'h0, ~wb, ~ab, ~db, ~pb};
        #1;
        ra = {rd_a, rp_a};
        rb = {rd_b, rp_b};
    endtask
endmodule

//--- verilog/bram_cfg.svh
// sizes, layout and reset values of the dual-port block ram
`ifndef BRAM_CFG_SVH
`define BRAM_CFG_SVH

`define BRAM_WORDS 512
`define BRAM_WORD_AW 9
`define BRAM_WORD_BITS 36
`define BRAM_DATA_BITS 32
`define BRAM_PAR_BITS 4
`define BRAM_PAR_POS 32
`define BRAM_LANE_BITS 8
`define BRAM_DEF_DW 32
`define BRAM_DOUT_RST 32'h0000_0000
`define BRAM_POUT_RST 4'h0

`endif

//--- verilog/bram_pkg.sv
// types shared by the dual-port block ram files
`include "bram_cfg.svh"

package bram_pkg;

    typedef enum logic {
        WRITE_NEW = 1'b0,
        READ_OLD = 1'b1
    } wr_mode_t;

    typedef struct packed {
        logic [`BRAM_DATA_BITS-1:0] data;
        logic [`BRAM_PAR_BITS-1:0] parity;
    } port_out_t;

    typedef struct packed {
        port_out_t a;
        port_out_t b;
    } ram_state_t;

endpackage

//--- verilog/bram_port_map.sv
// maps one port's address and width onto a 36-bit memory word
`include "bram_cfg.svh"

module bram_port_map #(
    parameter int DW = `BRAM_DEF_DW,
    localparam int PW = DW / `BRAM_LANE_BITS,
    localparam int PWP = (PW == 0) ? 1 : PW,
    localparam int SB = $clog2(`BRAM_DATA_BITS / DW),
    localparam int AW = `BRAM_WORD_AW + SB
) (
    // request side
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic [PWP-1:0] wparity,
    input wire logic [`BRAM_WORD_BITS-1:0] rword,
    // word side
    output logic [`BRAM_WORD_AW-1:0] widx,
    output logic [`BRAM_WORD_BITS-1:0] wmask,
    output logic [`BRAM_WORD_BITS-1:0] wbits,
    output logic [DW-1:0] rdata,
    output logic [PWP-1:0] rparity
);

    logic [4:0] slot;
    logic [4:0] dshift;
    logic [`BRAM_DATA_BITS-1:0] dmask;
    logic [`BRAM_DATA_BITS-1:0] dbits;
    logic [`BRAM_PAR_BITS-1:0] pmask;
    logic [`BRAM_PAR_BITS-1:0] pbits;

    // low address bits pick the slot inside the word, the rest the word
    generate
        if (SB == 0) begin : g_full
            assign slot = 5'h00;
        end else begin : g_slot
            assign slot = 5'(addr[SB-1:0]);
        end
    endgenerate

    assign widx = addr[AW-1:SB];

    always_comb begin
        dshift = 5'(int'(slot) * DW);
        dmask = '0;
        dbits = '0;
        dmask[dshift +: DW] = '1;
        dbits[dshift +: DW] = wdata;
        rdata = rword[dshift +: DW];
    end

    // one parity bit per byte lane; narrow widths leave parity untouched
    generate
        if (PW == 0) begin : g_nopar
            assign pmask = '0;
            assign pbits = '0;
            assign rparity = '0;
        end else begin : g_par
            logic [1:0] pshift;
            always_comb begin
                pshift = 2'(int'(slot) * PW);
                pmask = '0;
                pbits = '0;
                pmask[pshift +: PW] = '1;
                pbits[pshift +: PW] = wparity;
                rparity = rword[`BRAM_PAR_POS + int'(pshift) +: PW];
            end
        end
    endgenerate

    assign wmask = {pmask, dmask};
    assign wbits = {pbits, dbits};

endmodule

//--- verilog/dual_port_block_ram.sv
// dual-port block ram with selectable aspect ratio and write mode per port
`include "bram_cfg.svh"

module dual_port_block_ram #(
    parameter int DW_A = `BRAM_DEF_DW,
    parameter bram_pkg::wr_mode_t MODE_A = bram_pkg::WRITE_NEW,
    parameter int DW_B = `BRAM_DEF_DW,
    parameter bram_pkg::wr_mode_t MODE_B = bram_pkg::WRITE_NEW,
    localparam int PW_A = DW_A / `BRAM_LANE_BITS,
    localparam int PWP_A = (PW_A == 0) ? 1 : PW_A,
    localparam int AW_A = `BRAM_WORD_AW + $clog2(`BRAM_DATA_BITS / DW_A),
    localparam int PW_B = DW_B / `BRAM_LANE_BITS,
    localparam int PWP_B = (PW_B == 0) ? 1 : PW_B,
    localparam int AW_B = `BRAM_WORD_AW + $clog2(`BRAM_DATA_BITS / DW_B)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // port a
    input wire logic port_en_a,
    input wire logic port_we_a,
    input wire logic [AW_A-1:0] port_addr_a,
    input wire logic [DW_A-1:0] port_wdata_a,
    input wire logic [PWP_A-1:0] port_wparity_a,
    output logic [DW_A-1:0] port_rdata_a,
    output logic [PWP_A-1:0] port_rparity_a,
    // port b
    input wire logic port_en_b,
    input wire logic port_we_b,
    input wire logic [AW_B-1:0] port_addr_b,
    input wire logic [DW_B-1:0] port_wdata_b,
    input wire logic [PWP_B-1:0] port_wparity_b,
    output logic [DW_B-1:0] port_rdata_b,
    output logic [PWP_B-1:0] port_rparity_b
);

    logic [`BRAM_WORD_BITS-1:0] mem_q [`BRAM_WORDS];

    logic [`BRAM_WORD_AW-1:0] widx_a;
    logic [`BRAM_WORD_AW-1:0] widx_b;
    logic [`BRAM_WORD_BITS-1:0] wmask_a;
    logic [`BRAM_WORD_BITS-1:0] wmask_b;
    logic [`BRAM_WORD_BITS-1:0] wbits_a;
    logic [`BRAM_WORD_BITS-1:0] wbits_b;
    logic [`BRAM_WORD_BITS-1:0] rword_a;
    logic [`BRAM_WORD_BITS-1:0] rword_b;
    logic [`BRAM_WORD_BITS-1:0] base_a;
    logic [`BRAM_WORD_BITS-1:0] new_a;
    logic [`BRAM_WORD_BITS-1:0] new_b;
    logic [DW_A-1:0] rd_a;
    logic [DW_B-1:0] rd_b;
    logic [PWP_A-1:0] rp_a;
    logic [PWP_B-1:0] rp_b;
    logic wr_a;
    logic wr_b;

    bram_pkg::ram_state_t st_q;
    bram_pkg::ram_state_t st_d;

    assign wr_a = port_en_a & port_we_a;
    assign wr_b = port_en_b & port_we_b;
    assign rword_a = mem_q[widx_a];
    assign rword_b = mem_q[widx_b];

    bram_port_map #(
        .DW(DW_A)
    ) u_map_a (
        .addr(port_addr_a),
        .wdata(port_wdata_a),
        .wparity(port_wparity_a),
        .rword(rword_a),
        .widx(widx_a),
        .wmask(wmask_a),
        .wbits(wbits_a),
        .rdata(rd_a),
        .rparity(rp_a)
    );

    bram_port_map #(
        .DW(DW_B)
    ) u_map_b (
        .addr(port_addr_b),
        .wdata(port_wdata_b),
        .wparity(port_wparity_b),
        .rword(rword_b),
        .widx(widx_b),
        .wmask(wmask_b),
        .wbits(wbits_b),
        .rdata(rd_b),
        .rparity(rp_b)
    );

    // both ports may hit one word; merge so a wins only on overlapping bits
    always_comb begin
        new_b = (rword_b & ~wmask_b) | wbits_b;
        base_a = rword_a;
        if (wr_b && (widx_b == widx_a)) begin
            base_a = new_b;
        end
        new_a = (base_a & ~wmask_a) | wbits_a;
    end

    // storage is not reset, like a real ram macro
    always_ff @(posedge clk) begin
        if (wr_b) begin
            mem_q[widx_b] <= new_b;
        end
        if (wr_a) begin
            mem_q[widx_a] <= new_a;
        end
    end

    // output latches; reads see contents from before this edge's writes
    always_comb begin
        st_d = st_q;
        if (port_en_a) begin
            if (port_we_a && (MODE_A == bram_pkg::WRITE_NEW)) begin
                st_d.a.data = 32'(port_wdata_a);
                st_d.a.parity = (PW_A > 0) ? 4'(port_wparity_a) : 4'h0;
            end else begin
                st_d.a.data = 32'(rd_a);
                st_d.a.parity = 4'(rp_a);
            end
        end
        if (port_en_b) begin
            if (port_we_b && (MODE_B == bram_pkg::WRITE_NEW)) begin
                st_d.b.data = 32'(port_wdata_b);
                st_d.b.parity = (PW_B > 0) ? 4'(port_wparity_b) : 4'h0;
            end else begin
                st_d.b.data = 32'(rd_b);
                st_d.b.parity = 4'(rp_b);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{a: '{data: `BRAM_DOUT_RST, parity: `BRAM_POUT_RST},
                      b: '{data: `BRAM_DOUT_RST, parity: `BRAM_POUT_RST}};
        end else begin
            st_q <= st_d;
        end
    end

    assign port_rdata_a = st_q.a.data[DW_A-1:0];
    assign port_rparity_a = st_q.a.parity[PWP_A-1:0];
    assign port_rdata_b = st_q.b.data[DW_B-1:0];
    assign port_rparity_b = st_q.b.parity[PWP_B-1:0];

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_solo_wr_a;
        wr_a && !(wr_b && (widx_b == widx_a));
    endsequence

    sequence s_solo_wr_b;
        wr_b && !(wr_a && (widx_a == widx_b));
    endsequence

    sequence s_stored_a;
        (mem_q[$past(widx_a)] & $past(wmask_a)) == $past(wbits_a);
    endsequence

    sequence s_stored_b;
        (mem_q[$past(widx_b)] & $past(wmask_b)) == $past(wbits_b);
    endsequence

    property p_write_a;
        s_solo_wr_a |=> s_stored_a;
    endproperty
    a_write_a: assert property (p_write_a) else $error("port a write not stored");

    property p_write_b;
        s_solo_wr_b |=> s_stored_b;
    endproperty
    a_write_b: assert property (p_write_b) else $error("port b write not stored");

    sequence s_old_wr_a;
        (MODE_A == bram_pkg::READ_OLD) && wr_a && !(wr_b && (widx_b == widx_a));
    endsequence

    sequence s_old_wr_b;
        (MODE_B == bram_pkg::READ_OLD) && wr_b && !(wr_a && (widx_a == widx_b));
    endsequence

    sequence s_old_out_a;
        port_rdata_a == $past(rd_a);
    endsequence

    sequence s_old_out_b;
        port_rdata_b == $past(rd_b);
    endsequence

    property p_read_a;
        (port_en_a && !port_we_a)
            |=> (port_rdata_a == $past(rd_a)) && (port_rparity_a == $past(rp_a));
    endproperty
    a_read_a: assert property (p_read_a) else $error("port a read word wrong");

    property p_read_b;
        (port_en_b && !port_we_b)
            |=> (port_rdata_b == $past(rd_b)) && (port_rparity_b == $past(rp_b));
    endproperty
    a_read_b: assert property (p_read_b) else $error("port b read word wrong");

    property p_new_a;
        (MODE_A == bram_pkg::WRITE_NEW && wr_a) |=> (port_rdata_a == $past(port_wdata_a));
    endproperty
    a_new_a: assert property (p_new_a) else $error("port a new data not shown");

    // old word shown and new word stored on the same edge, both checked one cycle later
    property p_old_a;
        s_old_wr_a |=> s_old_out_a ##0 s_stored_a;
    endproperty
    a_old_a: assert property (p_old_a) else $error("port a old data not shown first");

    property p_old_b;
        s_old_wr_b |=> s_old_out_b ##0 s_stored_b;
    endproperty
    a_old_b: assert property (p_old_b) else $error("port b old data not shown first");

    property p_hold_a;
        !port_en_a |=> ($stable(port_rdata_a) && $stable(port_rparity_a));
    endproperty
    a_hold_a: assert property (p_hold_a) else $error("port a output moved while off");

    property p_indep_b;
        (wr_a && !port_en_b) |=> ($stable(port_rdata_b) && $stable(port_rparity_b));
    endproperty
    a_indep_b: assert property (p_indep_b) else $error("port b moved by port a");

    property p_par_a;
        (MODE_A == bram_pkg::WRITE_NEW && wr_a)
            |=> (port_rparity_a == ((PW_A > 0) ? $past(port_wparity_a) : '0));
    endproperty
    a_par_a: assert property (p_par_a) else $error("port a parity not shown with write");

endmodule
